// ### src/pmon_regs.sv
/*
 * live sample, status, key and unlock registers of the power monitor,
 * reached over an axi4-lite slave; interrupt from sticky event bits.
 * assumes samples and fault levels come from logic on the same clock.
 */
// The AXI4-Lite interface to the registers was left to the implementer.
// Functional notes
// - voltage sample shown signed q1.15 in bits 15:0 of sample word
// - current sample shown signed q1.15 in bits 31:16 of sample word
// - power is voltage times current, in bits 15:0 of power word
// - power result is signed q1.15
// - status bit 0 shows crossings whatever the pin functions
// - crossing bit follows half-period and square-wave modes
// - status bit 1 is live overcurrent, set only while present
// - status bit 2 latches overcurrent and holds after it goes
// - latched overcurrent cleared only by writing one to bit 2
// - status bit 3 is live overvoltage
// - status bit 4 is live undervoltage
// - 32-bit key register; open key value grants user access
// - unlock register bit 0: 0 locked, 1 user access granted
`timescale 1ns/1ps
`default_nettype none

module pmon_regs (
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic [15:0] i_volt,
    input  wire logic [15:0] i_curr,
    input  wire logic        i_sample_valid,
    input  wire logic        i_overcurrent,
    input  wire logic        i_overvoltage,
    input  wire logic        i_undervoltage,
    input  wire logic [9:0]  i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic      [1:0]  o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [9:0]  i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic      [31:0] o_rdata,
    output logic      [1:0]  o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    output logic             o_irq
);
    logic [31:0]                   sample_r;
    logic [15:0]                   power_r;
    logic [15:0]                   prod;
    logic                          prod_valid;
    logic                          cross_flag;
    logic                          cross_event;
    logic                          oc_live_r;
    logic                          oc_sticky_r;
    logic                          ov_r;
    logic                          uv_r;
    logic [31:0]                   key_r;
    logic                          unlock_r;
    logic [pmon_pkg::MODE_W-1:0]   mode_r;
    logic [pmon_pkg::IRQ_W-1:0]    irq_stat_r;
    logic [pmon_pkg::IRQ_W-1:0]    irq_mask_r;
    logic [pmon_pkg::IRQ_W-1:0]    irq_ev;
    logic [pmon_pkg::ADDR_W-1:0]   aw_addr_r;
    logic [31:0]                   w_data_r;
    logic [3:0]                    w_strb_r;
    logic                          wr_go;
    logic [7:0]                    wr_idx;
    logic [7:0]                    rd_idx;
    logic [pmon_pkg::STATUS_W-1:0] status_w;
    logic                          sticky_clr;
    logic [31:0]                   key_nxt;
    logic [1:0]                    wr_resp;
    logic [31:0]                   rd_word;
    logic [1:0]                    rd_resp;

    // ==================================================================
    // datapath helpers
    pmon_q15_mult u_mult (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_a      (i_volt),
        .i_b      (i_curr),
        .i_valid  (i_sample_valid),
        .o_p      (prod),
        .o_valid  (prod_valid)
    );

    pmon_cross_det u_cross (
        .i_clk       (i_clk),
        .i_resetn    (i_resetn),
        .i_sample    (i_volt),
        .i_valid     (i_sample_valid),
        .i_half_en   (mode_r[pmon_pkg::MODE_HALF]),
        .i_toggle_en (mode_r[pmon_pkg::MODE_TOGGLE]),
        .o_flag      (cross_flag),
        .o_event     (cross_event)
    );

    // ==================================================================
    // live samples
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            sample_r <= 32'h00000000;
        end else if (i_sample_valid) begin
            sample_r[15:0]  <= i_volt;
            sample_r[31:16] <= i_curr;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            power_r <= 16'h0000;
        end else if (prod_valid) begin
            power_r <= prod;
        end
    end

    // ==================================================================
    // write decode
    assign wr_go  = !o_awready && !o_wready && !o_bvalid;
    assign wr_idx = aw_addr_r[pmon_pkg::ADDR_W-1:2];
    assign key_nxt = pmon_pkg::merge_strb(key_r, w_data_r, w_strb_r);
    assign sticky_clr = wr_go && wr_idx == pmon_pkg::IDX_STATUS
                        && w_strb_r[0] && w_data_r[pmon_pkg::ST_OC_STICKY];

    always_comb begin
        unique case (wr_idx)
            pmon_pkg::IDX_STATUS,
            pmon_pkg::IDX_KEY,
            pmon_pkg::IDX_IRQ_STAT,
            pmon_pkg::IDX_IRQ_MASK: wr_resp = pmon_pkg::RESP_OKAY;
            pmon_pkg::IDX_MODE: begin
                wr_resp = unlock_r ? pmon_pkg::RESP_OKAY
                                   : pmon_pkg::RESP_SLVERR;
            end
            default: wr_resp = pmon_pkg::RESP_SLVERR;
        endcase
    end

    // ==================================================================
    // fault flags
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            oc_live_r <= 1'b0;
            ov_r      <= 1'b0;
            uv_r      <= 1'b0;
        end else begin
            oc_live_r <= i_overcurrent;
            ov_r      <= i_overvoltage;
            uv_r      <= i_undervoltage;
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            oc_sticky_r <= 1'b0;
        end else begin
            oc_sticky_r <= i_overcurrent
                           || (oc_sticky_r && !sticky_clr);
        end
    end

    assign status_w = {uv_r, ov_r, oc_sticky_r, oc_live_r, cross_flag};

    // ==================================================================
    // key, unlock and mode
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            key_r    <= 32'h00000000;
            unlock_r <= 1'b0;
        end else if (wr_go && wr_idx == pmon_pkg::IDX_KEY) begin
            key_r    <= key_nxt;
            unlock_r <= key_nxt == pmon_pkg::KEY_OPEN;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            mode_r <= '0;
        end else if (wr_go && wr_idx == pmon_pkg::IDX_MODE
                     && unlock_r && w_strb_r[0]) begin
            mode_r <= w_data_r[pmon_pkg::MODE_W-1:0];
        end
    end

    // ==================================================================
    // interrupt status, mask and output
    assign irq_ev = {i_undervoltage && !uv_r, i_overvoltage && !ov_r,
                     i_overcurrent && !oc_live_r, cross_event};

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            irq_stat_r <= '0;
        end else if (wr_go && wr_idx == pmon_pkg::IDX_IRQ_STAT
                     && w_strb_r[0]) begin
            irq_stat_r <= irq_ev
                          | (irq_stat_r & ~w_data_r[pmon_pkg::IRQ_W-1:0]);
        end else begin
            irq_stat_r <= irq_stat_r | irq_ev;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            irq_mask_r <= '0;
        end else if (wr_go && wr_idx == pmon_pkg::IDX_IRQ_MASK
                     && w_strb_r[0]) begin
            irq_mask_r <= w_data_r[pmon_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_stat_r & irq_mask_r);
        end
    end

    // ==================================================================
    // write channels
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_awready <= 1'b1;
            o_wready  <= 1'b1;
        end else begin
            if (i_awvalid && o_awready) begin
                o_awready <= 1'b0;
            end else if (o_bvalid && i_bready) begin
                o_awready <= 1'b1;
            end
            if (i_wvalid && o_wready) begin
                o_wready <= 1'b0;
            end else if (o_bvalid && i_bready) begin
                o_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            aw_addr_r <= '0;
            w_data_r  <= 32'h00000000;
            w_strb_r  <= 4'h0;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_addr_r <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_data_r <= i_wdata;
                w_strb_r <= i_wstrb;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_bvalid <= 1'b0;
            o_bresp  <= pmon_pkg::RESP_OKAY;
        end else if (wr_go) begin
            o_bvalid <= 1'b1;
            o_bresp  <= wr_resp;
        end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // ==================================================================
    // read channel
    assign rd_idx = i_araddr[pmon_pkg::ADDR_W-1:2];

    always_comb begin
        rd_word = 32'h00000000;
        rd_resp = pmon_pkg::RESP_OKAY;
        unique case (rd_idx)
            pmon_pkg::IDX_SAMPLE:   rd_word = sample_r;
            pmon_pkg::IDX_POWER:    rd_word[15:0] = power_r;
            pmon_pkg::IDX_STATUS:   rd_word[pmon_pkg::STATUS_W-1:0] = status_w;
            pmon_pkg::IDX_KEY:      rd_word = key_r;
            pmon_pkg::IDX_UNLOCK:   rd_word[0] = unlock_r;
            pmon_pkg::IDX_MODE:     rd_word[pmon_pkg::MODE_W-1:0] = mode_r;
            pmon_pkg::IDX_IRQ_STAT: rd_word[pmon_pkg::IRQ_W-1:0] = irq_stat_r;
            pmon_pkg::IDX_IRQ_MASK: rd_word[pmon_pkg::IRQ_W-1:0] = irq_mask_r;
            default:                rd_resp = pmon_pkg::RESP_SLVERR;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h00000000;
            o_rresp   <= pmon_pkg::RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            o_rdata   <= rd_word;
            o_rresp   <= rd_resp;
        end else if (o_rvalid && i_rready) begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
        end
    end

    // ==================================================================
    // checks
    sequence key_open_s;
        wr_go && wr_idx == pmon_pkg::IDX_KEY
        && key_nxt == pmon_pkg::KEY_OPEN;
    endsequence

    sequence mode_write_s;
        wr_go && wr_idx == pmon_pkg::IDX_MODE;
    endsequence

    volt_sample_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_sample_valid |=> sample_r[15:0] == $past(i_volt))
        else $error("voltage sample not captured");
    curr_sample_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_sample_valid |=> sample_r[31:16] == $past(i_curr))
        else $error("current sample not captured");
    power_update_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_sample_valid && i_volt == pmon_pkg::Q_MIN
        && i_curr == pmon_pkg::Q_MIN |=> ##1 power_r == pmon_pkg::Q_MAX)
        else $error("power word not updated two cycles after sample");
    oc_live_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        ##1 oc_live_r == $past(i_overcurrent))
        else $error("live overcurrent flag wrong");
    oc_sticky_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_overcurrent ##1 !i_overcurrent && !sticky_clr
        |=> oc_sticky_r)
        else $error("latched overcurrent not held");
    sticky_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $fell(oc_sticky_r) |-> $past(sticky_clr)
        && !$past(i_overcurrent))
        else $error("latched overcurrent cleared without write");
    volt_flags_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        ##1 status_w[pmon_pkg::ST_OV] == $past(i_overvoltage)
        && status_w[pmon_pkg::ST_UV] == $past(i_undervoltage))
        else $error("voltage fault flags wrong");
    key_unlock_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        key_open_s |=> unlock_r && key_r == pmon_pkg::KEY_OPEN)
        else $error("open key did not unlock");
    unlock_read_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_arvalid && o_arready && rd_idx == pmon_pkg::IDX_UNLOCK
        |=> o_rvalid && o_rdata == {31'h0, $past(unlock_r)})
        else $error("unlock bit read wrong");
    mode_lock_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        mode_write_s ##0 !unlock_r
        |=> $stable(mode_r) && o_bresp == pmon_pkg::RESP_SLVERR)
        else $error("locked mode write not refused");
endmodule // pmon_regs

`default_nettype wire

// ### src/pmon_pkg.sv
/*
 * constants for the live sample and status register bank: register
 * indices, field positions, key value, bus responses, fixed-point limits.
 * assumes a 32-bit register bus, byte address = index times four.
 */
`default_nettype none

package pmon_pkg;
    // ==================================================================
    // register indices
    localparam logic [7:0]  IDX_SAMPLE   = 8'h2A;
    localparam logic [7:0]  IDX_POWER    = 8'h2C;
    localparam logic [7:0]  IDX_STATUS   = 8'h2D;
    localparam logic [7:0]  IDX_KEY      = 8'h2F;
    localparam logic [7:0]  IDX_UNLOCK   = 8'h30;
    localparam logic [7:0]  IDX_MODE     = 8'h31;
    localparam logic [7:0]  IDX_IRQ_STAT = 8'h32;
    localparam logic [7:0]  IDX_IRQ_MASK = 8'h33;
    localparam int          ADDR_W       = 10;
    // ==================================================================
    // field positions
    localparam int          ST_CROSS     = 0;
    localparam int          ST_OC_LIVE   = 1;
    localparam int          ST_OC_STICKY = 2;
    localparam int          ST_OV        = 3;
    localparam int          ST_UV        = 4;
    localparam int          STATUS_W     = 5;
    localparam int          MODE_HALF    = 0;
    localparam int          MODE_TOGGLE  = 1;
    localparam int          MODE_W       = 2;
    localparam int          IRQ_W        = 4;
    localparam int          HALF_W       = 16;
    // ==================================================================
    // values
    localparam logic [31:0] KEY_OPEN     = 32'h4F70656E;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    localparam logic [15:0] Q_MAX        = 16'h7FFF;
    localparam logic [15:0] Q_MIN        = 16'h8000;
    localparam int          Q_FRAC       = 15;

    // byte-lane merge of a bus write into a stored word
    function automatic logic [31:0] merge_strb(
        input logic [31:0] old_w,
        input logic [31:0] new_w,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return res;
    endfunction
endpackage

`default_nettype wire

// ### src/pmon_q15_mult.sv
/*
 * signed q1.15 multiplier, one registered stage.
 * assumes operands arrive with a one-cycle valid on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module pmon_q15_mult (
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic [15:0] i_a,
    input  wire logic [15:0] i_b,
    input  wire logic        i_valid,
    output logic      [15:0] o_p,
    output logic             o_valid
);
    logic signed [31:0] prod;
    logic        [15:0] res;

    // ==================================================================
    // product, saturated at the one corner that overflows
    always_comb begin
        prod = $signed(i_a) * $signed(i_b);
        res  = prod[pmon_pkg::Q_FRAC +: 16];
        if (i_a == pmon_pkg::Q_MIN && i_b == pmon_pkg::Q_MIN) begin
            res = pmon_pkg::Q_MAX;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_p     <= 16'h0000;
            o_valid <= 1'b0;
        end else begin
            o_valid <= i_valid;
            if (i_valid) begin
                o_p <= res;
            end
        end
    end

    // ==================================================================
    // checks
    half_prod_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_valid && i_a == 16'h4000 && i_b == 16'h4000
        |=> o_valid && o_p == 16'h2000)
        else $error("q15 product of halves wrong");
    sat_corner_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_valid && i_a == pmon_pkg::Q_MIN && i_b == pmon_pkg::Q_MIN
        |=> o_p == pmon_pkg::Q_MAX)
        else $error("q15 product not saturated");
endmodule // pmon_q15_mult

`default_nettype wire

// ### src/pmon_cross_det.sv
/*
 * zero-crossing detector on the sign of the voltage sample.
 * assumes one-cycle sample valid strobes on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module pmon_cross_det (
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic [15:0] i_sample,
    input  wire logic        i_valid,
    input  wire logic        i_half_en,
    input  wire logic        i_toggle_en,
    output logic             o_flag,
    output logic             o_event
);
    logic neg_prev_r;
    logic primed_r;
    logic neg;
    logic counted;

    // ==================================================================
    // both edges in half-period mode, else rising edges only
    assign neg     = i_sample[pmon_pkg::HALF_W-1];
    assign counted = primed_r && (neg != neg_prev_r)
                     && (i_half_en || !neg);

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            neg_prev_r <= 1'b0;
            primed_r   <= 1'b0;
        end else if (i_valid) begin
            neg_prev_r <= neg;
            primed_r   <= 1'b1;
        end
    end

    // ==================================================================
    // square wave toggles, otherwise flag lasts one sample period
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_flag  <= 1'b0;
            o_event <= 1'b0;
        end else begin
            o_event <= i_valid && counted;
            if (i_valid) begin
                o_flag <= i_toggle_en ? (o_flag ^ counted) : counted;
            end
        end
    end

    toggle_flip_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_valid && i_toggle_en && counted
        |=> o_flag != $past(o_flag) && o_event)
        else $error("square wave flag did not toggle");
endmodule // pmon_cross_det

`default_nettype wire

// ### dv/pmon_host.sv
/*
 * host model on the axi4-lite register bus, one transfer at a time.
 * assumes the slave runs on i_clk; the bench bounds every wait.
 */
`timescale 1ns/1ps
`default_nettype none

module pmon_host (
    input  wire logic        i_clk,
    output logic      [9:0]  o_awaddr,
    output logic             o_awvalid,
    input  wire logic        i_awready,
    output logic      [31:0] o_wdata,
    output logic      [3:0]  o_wstrb,
    output logic             o_wvalid,
    input  wire logic        i_wready,
    input  wire logic [1:0]  i_bresp,
    input  wire logic        i_bvalid,
    output logic             o_bready,
    output logic      [9:0]  o_araddr,
    output logic             o_arvalid,
    input  wire logic        i_arready,
    input  wire logic [31:0] i_rdata,
    input  wire logic [1:0]  i_rresp,
    input  wire logic        i_rvalid,
    output logic             o_rready
);
    // ==================================================================
    // bus cycles; released lines other than o_wstrb show the inverse of their last value
    initial begin
        o_awaddr = '0;
        o_wdata = '0;
        o_wstrb = '0;
        o_araddr = '0;
        o_awvalid = 1'b0;
        o_wvalid = 1'b0;
        o_bready = 1'b0;
        o_arvalid = 1'b0;
        o_rready = 1'b0;
    end

    task automatic wr(input logic [9:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        @(posedge i_clk);
        o_awaddr <= a;
        o_wdata <= d;
        o_wstrb <= 4'hF;
        o_awvalid <= 1'b1;
        o_wvalid <= 1'b1;
        o_bready <= 1'b1;
        forever begin
            @(posedge i_clk);
            if (o_awvalid && i_awready) begin
                o_awvalid <= 1'b0;
                o_awaddr <= ~a;
            end
            if (o_wvalid && i_wready) begin
                o_wvalid <= 1'b0;
                o_wdata <= ~d;
            end
            if (i_bvalid) begin
                r = i_bresp;
                o_bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rd(input logic [9:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge i_clk);
        o_araddr <= a;
        o_arvalid <= 1'b1;
        o_rready <= 1'b1;
        forever begin
            @(posedge i_clk);
            if (o_arvalid && i_arready) begin
                o_arvalid <= 1'b0;
                o_araddr <= ~a;
            end
            if (i_rvalid) begin
                d = i_rdata;
                r = i_rresp;
                o_rready <= 1'b0;
                break;
            end
        end
    endtask
endmodule // pmon_host

`default_nettype wire

// ### dv/tb_top.sv
/*
 * self-checking bench for the sample and status register bank.
 * assumes the host model in pmon_host and the package constants.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic        i_clk, i_resetn, i_sample_valid, i_overcurrent;
    logic        i_overvoltage, i_undervoltage, i_awvalid, o_awready;
    logic        i_wvalid, o_wready, o_bvalid, i_bready, i_arvalid;
    logic        o_arready, o_rvalid, i_rready, o_irq;
    logic [15:0] i_volt, i_curr;
    logic [9:0]  i_awaddr, i_araddr;
    logic [31:0] i_wdata, o_rdata, rd_v;
    logic [3:0]  i_wstrb;
    logic [1:0]  o_bresp, o_rresp, rsp;
    int          n_errors, comparisons;
    // rows: voltage, current, power, crossing bit
    logic [51:0] rows [4] = '{{16'h4000, 16'h4000, 16'h2000, 4'h0},
        {16'h8000, 16'h8000, 16'h7FFF, 4'h0},
        {16'hC000, 16'h4000, 16'hE000, 4'h0},
        {16'h7FFF, 16'h0000, 16'h0000, 4'h1}};
    localparam logic [9:0] A_SMP = {pmon_pkg::IDX_SAMPLE, 2'b00};
    localparam logic [9:0] A_PWR = {pmon_pkg::IDX_POWER, 2'b00};
    localparam logic [9:0] A_ST  = {pmon_pkg::IDX_STATUS, 2'b00};
    localparam logic [9:0] A_KEY = {pmon_pkg::IDX_KEY, 2'b00};
    localparam logic [9:0] A_UNL = {pmon_pkg::IDX_UNLOCK, 2'b00};
    localparam logic [9:0] A_MOD = {pmon_pkg::IDX_MODE, 2'b00};
    localparam logic [9:0] A_IST = {pmon_pkg::IDX_IRQ_STAT, 2'b00};
    localparam logic [9:0] A_IMK = {pmon_pkg::IDX_IRQ_MASK, 2'b00};

    initial i_clk = 1'b0;
    always #2.5 i_clk = ~i_clk;

    pmon_regs u_dut (
        .i_clk, .i_resetn, .i_volt, .i_curr, .i_sample_valid,
        .i_overcurrent, .i_overvoltage, .i_undervoltage, .i_awaddr,
        .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready,
        .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
        .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_irq
    );
    pmon_host u_host (
        .i_clk, .o_awaddr(i_awaddr), .o_awvalid(i_awvalid),
        .i_awready(o_awready), .o_wdata(i_wdata), .o_wstrb(i_wstrb),
        .o_wvalid(i_wvalid), .i_wready(o_wready), .i_bresp(o_bresp),
        .i_bvalid(o_bvalid), .o_bready(i_bready), .o_araddr(i_araddr),
        .o_arvalid(i_arvalid), .i_arready(o_arready), .i_rdata(o_rdata),
        .i_rresp(o_rresp), .i_rvalid(o_rvalid), .o_rready(i_rready)
    );
    // ==================================================================
    // helpers
    task automatic chk(input string nm, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic rd(input logic [9:0] a, input string nm,
                      input logic [31:0] e);
        u_host.rd(a, rd_v, rsp);
        chk(nm, rd_v, e);
    endtask
    task automatic wrx(input logic [9:0] a, input logic [31:0] d,
                       input logic [1:0] e);
        u_host.wr(a, d, rsp);
        chk("bresp", {30'h0, rsp}, {30'h0, e});
    endtask
    task automatic smp(input logic [15:0] v, c);
        @(posedge i_clk);
        i_volt <= v;
        i_curr <= c;
        i_sample_valid <= 1'b1;
        @(posedge i_clk);
        i_sample_valid <= 1'b0;
        i_volt <= ~v;
        i_curr <= ~c;
        repeat (3) @(posedge i_clk);
    endtask
    task automatic flt(input logic oc, ov, uv);
        @(posedge i_clk);
        i_overcurrent <= oc;
        i_overvoltage <= ov;
        i_undervoltage <= uv;
        repeat (3) @(posedge i_clk);
    endtask
    task automatic wrap_up;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ==================================================================
    // tests
    initial begin
        repeat (20000) @(posedge i_clk);
        n_errors++;
        wrap_up();
    end
    initial begin
        n_errors = 0;
        comparisons = 0;
        i_resetn = 1'b0;
        i_volt = '0;
        i_curr = '0;
        i_sample_valid = 1'b0;
        i_overcurrent = 1'b0;
        i_overvoltage = 1'b0;
        i_undervoltage = 1'b0;
        repeat (16) @(posedge i_clk);
        i_resetn <= 1'b1;
        @(negedge i_clk);
        chk("irq", {31'h0, o_irq}, 32'h0);
        rd(A_UNL, "unlock", 32'h0);
        for (int k = 0; k < 4; k++) begin
            smp(rows[k][51:36], rows[k][35:20]);
            rd(A_SMP, "sample", {rows[k][35:20], rows[k][51:36]});
            rd(A_PWR, "power", {16'h0, rows[k][19:4]});
            rd(A_ST, "crossing", {28'h0, rows[k][3:0]});
        end
        wrx(A_SMP, 32'h1, pmon_pkg::RESP_SLVERR);
        rd(10'h000, "unmapped", 32'h0);
        chk("rresp", {30'h0, rsp}, {30'h0, pmon_pkg::RESP_SLVERR});
        wrx(A_MOD, 32'h1, pmon_pkg::RESP_SLVERR);
        rd(A_MOD, "mode", 32'h0);
        wrx(A_KEY, pmon_pkg::KEY_OPEN, pmon_pkg::RESP_OKAY);
        rd(A_UNL, "unlock", 32'h1);
        wrx(A_MOD, 32'h1, pmon_pkg::RESP_OKAY);
        smp(16'h8000, 16'h0000);
        rd(A_ST, "half mode", 32'h1);
        wrx(A_MOD, 32'h3, pmon_pkg::RESP_OKAY);
        smp(16'h8000, 16'h0000);
        rd(A_ST, "square hold", 32'h1);
        smp(16'h4000, 16'h0000);
        rd(A_ST, "square flip", 32'h0);
        wrx(A_KEY, 32'h4F70656F, pmon_pkg::RESP_OKAY);
        rd(A_UNL, "relock", 32'h0);
        flt(1'b1, 1'b0, 1'b0);
        rd(A_ST, "oc live", 32'h6);
        flt(1'b0, 1'b0, 1'b0);
        rd(A_ST, "oc held", 32'h4);
        wrx(A_ST, 32'h0, pmon_pkg::RESP_OKAY);
        rd(A_ST, "oc kept", 32'h4);
        wrx(A_ST, 32'h4, pmon_pkg::RESP_OKAY);
        rd(A_ST, "oc clear", 32'h0);
        flt(1'b0, 1'b1, 1'b1);
        rd(A_ST, "ov uv", 32'h18);
        flt(1'b0, 1'b0, 1'b0);
        rd(A_ST, "ov uv off", 32'h0);
        rd(A_IST, "irq status", 32'hF);
        chk("irq masked", {31'h0, o_irq}, 32'h0);
        wrx(A_IMK, 32'hF, pmon_pkg::RESP_OKAY);
        repeat (2) @(negedge i_clk);
        chk("irq", {31'h0, o_irq}, 32'h1);
        wrx(A_IST, 32'hF, pmon_pkg::RESP_OKAY);
        repeat (2) @(negedge i_clk);
        chk("irq clear", {31'h0, o_irq}, 32'h0);
        wrap_up();
    end
endmodule // tb_top

`default_nettype wire
